// >>> dpdl_params.svh
// timing counts, coefficient addresses and limits for the duty-limited pid core
`ifndef DPDL_PARAMS_SVH
`define DPDL_PARAMS_SVH

// ---------------------------------------------------------------
// clock and switching period
// ---------------------------------------------------------------
`define DPDL_CLK_PERIOD_PS     4000
`define DPDL_SW_PERIOD_NS      2000
`define DPDL_PERIOD_CYCLES     ((`DPDL_SW_PERIOD_NS * 1000) / `DPDL_CLK_PERIOD_PS)
`define DPDL_CNT_W             10

// ---------------------------------------------------------------
// data widths
// ---------------------------------------------------------------
`define DPDL_ERR_W             6
`define DPDL_COEF_W            8
`define DPDL_INTEG_W           16
`define DPDL_SUM_W             27
`define DPDL_GAIN_SHIFT        4
`define DPDL_PCT_W             7
`define DPDL_PCT_FULL          7'h64

// ---------------------------------------------------------------
// non-volatile coefficient addresses
// ---------------------------------------------------------------
`define DPDL_NVM_ADDR_W        2
`define DPDL_NVM_ADDR_P        2'h0
`define DPDL_NVM_ADDR_I        2'h1
`define DPDL_NVM_ADDR_D        2'h2

`endif

// >>> dpdl_pkg.sv
// types shared by the duty-limited pid core
`default_nettype none

package dpdl_pkg;

  // ---------------------------------------------------------------
  // coefficient loader and regulation states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    DPDL_ST_LOAD_P = 4'b0001,  // fetching proportional coefficient
    DPDL_ST_LOAD_I = 4'b0010,  // fetching integral coefficient
    DPDL_ST_LOAD_D = 4'b0100,  // fetching derivative coefficient
    DPDL_ST_RUN    = 4'b1000   // closed-loop regulation
  } dpdl_state_t;

endpackage

`default_nettype wire

// >>> dpdl_pid.sv
// pid compensator: error samples in, clamped pulse width out
`include "dpdl_params.svh"
`default_nettype none

module dpdl_pid
  import dpdl_pkg::*;
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        clear,
  // error samples
  input  wire logic                        run,
  input  wire logic                        sample_valid,
  input  wire logic [`DPDL_ERR_W-1:0]      err_code,
  // coefficients
  input  wire logic [`DPDL_COEF_W-1:0]     proportional_coefficient,
  input  wire logic [`DPDL_COEF_W-1:0]     integral_coefficient,
  input  wire logic [`DPDL_COEF_W-1:0]     derivative_coefficient,
  // result
  output logic      [`DPDL_CNT_W-1:0]      width_reg
);

  // ---------------------------------------------------------------
  // state and arithmetic
  // ---------------------------------------------------------------
  logic signed [`DPDL_ERR_W-1:0]   err_prev_reg;   // previous sample
  logic signed [`DPDL_INTEG_W-1:0] integ_reg;      // accumulated error
  logic signed [`DPDL_ERR_W-1:0]   err_s;          // current sample, two's complement
  logic signed [`DPDL_INTEG_W:0]   integ_sum;      // unsaturated accumulation
  logic signed [`DPDL_INTEG_W-1:0] integ_next;     // saturated accumulation
  logic signed [`DPDL_ERR_W:0]     err_diff;       // first difference
  logic signed [14:0]              p_term;         // error times proportional
  logic signed [24:0]              i_term;         // integral times coefficient
  logic signed [15:0]              d_term;         // difference times derivative
  logic signed [`DPDL_SUM_W-1:0]   pid_sum;        // sum of the three terms
  logic signed [`DPDL_SUM_W-1:0]   pid_scaled;     // sum after gain shift
  logic        [`DPDL_CNT_W-1:0]   width_next;     // clamped pulse width
  logic signed [`DPDL_SUM_W-1:0]   period_s;       // period as signed bound

  assign err_s     = $signed(err_code);
  assign integ_sum = (`DPDL_INTEG_W+1)'(integ_reg) + (`DPDL_INTEG_W+1)'(err_s);
  // integral saturates rather than wrapping, so windup cannot flip sign
  assign integ_next = (integ_sum > (`DPDL_INTEG_W+1)'(17'sh07fff)) ? 16'sh7fff :
                      (integ_sum < (`DPDL_INTEG_W+1)'(-17'sh08000)) ? -16'sh8000 :
                      integ_sum[`DPDL_INTEG_W-1:0];
  assign err_diff  = (`DPDL_ERR_W+1)'(err_s) - (`DPDL_ERR_W+1)'(err_prev_reg);
  // each term scaled by its own coefficient [RULE_06]
  assign p_term    = err_s * $signed({1'b0, proportional_coefficient});
  assign i_term    = integ_next * $signed({1'b0, integral_coefficient});
  assign d_term    = 16'(err_diff * $signed({1'b0, derivative_coefficient}));
  assign pid_sum   = `DPDL_SUM_W'(p_term) + `DPDL_SUM_W'(i_term) + `DPDL_SUM_W'(d_term); // [RULE_06]
  assign pid_scaled = pid_sum >>> `DPDL_GAIN_SHIFT;
  assign period_s  = `DPDL_SUM_W'(`DPDL_PERIOD_CYCLES);
  // clamp to the valid pulse-width range 0..period [RULE_08]
  assign width_next = (pid_scaled < 0)        ? '0 :
                      (pid_scaled > period_s) ? `DPDL_CNT_W'(`DPDL_PERIOD_CYCLES) :
                      pid_scaled[`DPDL_CNT_W-1:0];

  // ---------------------------------------------------------------
  // sample update
  // ---------------------------------------------------------------
  // compensator state moves only on a valid sample while regulating
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_prev_reg <= '0;
      integ_reg    <= '0;
      width_reg    <= '0;
    end else if (clear) begin
      err_prev_reg <= '0;
      integ_reg    <= '0;
      width_reg    <= '0;
    end else if (run && sample_valid) begin
      err_prev_reg <= err_s;
      integ_reg    <= integ_next;  // [RULE_06]
      width_reg    <= width_next;  // [RULE_08]
    end
  end

endmodule

`default_nettype wire

// >>> dpdl_top.sv
// duty-limited pid core: reset hold, coefficient load, compensator and pwm
// Function
// [RULE_01] hold all logic reset until supply valid
// [RULE_02] pulse and low-side outputs low during reset
// [RULE_03] programmable on-time ceiling as period percentage
// [RULE_04] ceiling reached ends pulse until next cycle
// [RULE_05] power stage sends 6-bit quantised voltage error
// [RULE_06] output is scaled proportional, integral, derivative sum
// [RULE_07] load coefficients from nonvolatile storage before regulating
// [RULE_08] clamp result, apply ceiling, use next cycle
`include "dpdl_params.svh"
`default_nettype none

module dpdl_top
  import dpdl_pkg::*;
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // supply monitor
  input  wire logic                        supply_ok,
  // error samples from the power stage
  input  wire logic                        err_valid,
  input  wire logic [`DPDL_ERR_W-1:0]      err_code,
  // duty ceiling in percent of the period
  input  wire logic [`DPDL_PCT_W-1:0]      duty_limit_pct,
  // non-volatile coefficient read port
  output logic                             nvm_rd_req,
  output logic      [`DPDL_NVM_ADDR_W-1:0] nvm_addr,
  input  wire logic                        nvm_rd_valid,
  input  wire logic [`DPDL_COEF_W-1:0]     nvm_rd_data,
  // gate drive and status
  output logic                             pulse_width_out,
  output logic                             low_side_gate_drive,
  output logic                             regulating
);

  // ---------------------------------------------------------------
  // power-on reset hold
  // ---------------------------------------------------------------
  logic core_rst_reg;  // high while the supply is below threshold

  // internal reset stays asserted until the monitor reports a good supply
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_rst_reg <= 1'b1;
    end else begin
      core_rst_reg <= ~supply_ok;  // [RULE_01]
    end
  end

  // ---------------------------------------------------------------
  // coefficient loader
  // ---------------------------------------------------------------
  dpdl_state_t                  state_reg;       // loader / run state
  dpdl_state_t                  state_next;      // next state
  logic                         pending_reg;     // read issued, answer awaited
  logic [`DPDL_COEF_W-1:0]      kp_reg;          // working proportional coefficient
  logic [`DPDL_COEF_W-1:0]      ki_reg;          // working integral coefficient
  logic [`DPDL_COEF_W-1:0]      kd_reg;          // working derivative coefficient
  logic                         loading;         // any load state
  logic                         issue;           // launch a read this cycle
  logic                         got;             // answer taken this cycle
  logic [`DPDL_NVM_ADDR_W-1:0]  addr_sel;        // address for current state
  logic                         run;             // closed loop active

  assign run     = (state_reg == DPDL_ST_RUN);
  assign loading = ~run;
  assign issue   = loading & ~pending_reg;
  assign got     = loading & pending_reg & nvm_rd_valid;
  // each load state fetches its own coefficient address
  assign addr_sel = (state_reg == DPDL_ST_LOAD_P) ? `DPDL_NVM_ADDR_P :
                    (state_reg == DPDL_ST_LOAD_I) ? `DPDL_NVM_ADDR_I :
                    `DPDL_NVM_ADDR_D;

  // advance one coefficient per returned word, then regulate
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DPDL_ST_LOAD_P: begin
        if (got) begin
          state_next = DPDL_ST_LOAD_I;
        end
      end
      DPDL_ST_LOAD_I: begin
        if (got) begin
          state_next = DPDL_ST_LOAD_D;
        end
      end
      DPDL_ST_LOAD_D: begin
        if (got) begin
          state_next = DPDL_ST_RUN;  // [RULE_07]
        end
      end
      DPDL_ST_RUN: begin
        state_next = DPDL_ST_RUN;
      end
    endcase
  end

  // loader state and read handshake
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg   <= DPDL_ST_LOAD_P;
      pending_reg <= 1'b0;
      nvm_rd_req  <= 1'b0;
      nvm_addr    <= '0;
    end else if (core_rst_reg) begin
      state_reg   <= DPDL_ST_LOAD_P;  // [RULE_01]
      pending_reg <= 1'b0;
      nvm_rd_req  <= 1'b0;
      nvm_addr    <= '0;
    end else begin
      state_reg   <= state_next;
      pending_reg <= (pending_reg & ~nvm_rd_valid) | issue;
      nvm_rd_req  <= issue;
      nvm_addr    <= issue ? addr_sel : nvm_addr;
    end
  end

  // capture each returned coefficient into its working register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      kp_reg <= '0;
      ki_reg <= '0;
      kd_reg <= '0;
    end else if (core_rst_reg) begin
      // working coefficients are held cleared with the rest of the core
      kp_reg <= '0;  // [RULE_01]
      ki_reg <= '0;  // [RULE_01]
      kd_reg <= '0;  // [RULE_01]
    end else if (got) begin
      if (state_reg == DPDL_ST_LOAD_P) begin
        kp_reg <= nvm_rd_data;  // [RULE_07]
      end
      if (state_reg == DPDL_ST_LOAD_I) begin
        ki_reg <= nvm_rd_data;  // [RULE_07]
      end
      if (state_reg == DPDL_ST_LOAD_D) begin
        kd_reg <= nvm_rd_data;  // [RULE_07]
      end
    end
  end

  // ---------------------------------------------------------------
  // compensator
  // ---------------------------------------------------------------
  logic [`DPDL_CNT_W-1:0] pid_width;  // clamped compensator width

  // samples are 6-bit two's complement error codes [RULE_05]
  dpdl_pid u_pid (
    .clock                    (clock),
    .rst                      (rst),
    .clear                    (core_rst_reg),
    .run                      (run),
    .sample_valid             (err_valid),
    .err_code                 (err_code),
    .proportional_coefficient (kp_reg),
    .integral_coefficient     (ki_reg),
    .derivative_coefficient   (kd_reg),
    .width_reg                (pid_width)
  );

  // ---------------------------------------------------------------
  // duty ceiling
  // ---------------------------------------------------------------
  logic [`DPDL_PCT_W-1:0]    pct_clip;     // percent held at 100 at most
  logic [16:0]               ceil_prod;    // period times percent
  logic [`DPDL_CNT_W-1:0]    ceil_cnt;     // ceiling in clock cycles
  logic [`DPDL_CNT_W-1:0]    width_lim;    // width after ceiling

  assign pct_clip  = (duty_limit_pct > `DPDL_PCT_FULL) ? `DPDL_PCT_FULL : duty_limit_pct;
  // ceiling expressed as a share of the switching period [RULE_03]
  assign ceil_prod = 17'(`DPDL_PERIOD_CYCLES) * 17'(pct_clip);
  assign ceil_cnt  = `DPDL_CNT_W'(ceil_prod / 17'h64);
  // clamped width is then limited by the ceiling [RULE_08]
  assign width_lim = (pid_width > ceil_cnt) ? ceil_cnt : pid_width;

  // ---------------------------------------------------------------
  // switching period and gate drive
  // ---------------------------------------------------------------
  logic [`DPDL_CNT_W-1:0] cnt_reg;        // position in the period
  logic [`DPDL_CNT_W-1:0] width_act_reg;  // width in force this period
  logic                   hit_reg;        // ceiling reached this period
  logic                   wrap;           // last cycle of the period
  logic [`DPDL_CNT_W-1:0] cnt_next;       // next period position
  logic                   at_ceil;        // next position reaches ceiling
  logic                   hit_next;       // ceiling latch next value
  logic                   high_next;      // high-side drive next value

  assign wrap      = (cnt_reg == `DPDL_CNT_W'(`DPDL_PERIOD_CYCLES - 1));
  assign cnt_next  = wrap ? '0 : cnt_reg + `DPDL_CNT_W'(1);
  assign at_ceil   = (cnt_next >= ceil_cnt);
  // once reached, the ceiling holds the pulse off until the period restarts
  assign hit_next  = (wrap ? 1'b0 : hit_reg) | at_ceil;  // [RULE_04]
  assign high_next = run & ~hit_next &
                     (cnt_next < (wrap ? width_lim : width_act_reg)); // [RULE_03]

  // period counter, width taken at each period start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg       <= '0;
      width_act_reg <= '0;
      hit_reg       <= 1'b0;
    end else if (core_rst_reg) begin
      cnt_reg       <= '0;
      width_act_reg <= '0;
      hit_reg       <= 1'b0;
    end else begin
      cnt_reg       <= cnt_next;
      width_act_reg <= wrap ? width_lim : width_act_reg;  // [RULE_08]
      hit_reg       <= hit_next;                          // [RULE_04]
    end
  end

  // gate drive is forced low while reset or supply hold is active
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse_width_out     <= 1'b0;  // [RULE_02]
      low_side_gate_drive <= 1'b0;  // [RULE_02]
      regulating          <= 1'b0;
    end else if (core_rst_reg) begin
      pulse_width_out     <= 1'b0;  // [RULE_02]
      low_side_gate_drive <= 1'b0;  // [RULE_02]
      regulating          <= 1'b0;
    end else begin
      pulse_width_out     <= high_next;
      low_side_gate_drive <= run & ~high_next;
      regulating          <= run;
    end
  end

endmodule

`default_nettype wire

// >>> dpdl_props.sv
// port assertions for the duty-limited pid core
`include "dpdl_params.svh"
`default_nettype none

module dpdl_props
(
  // clock and reset
  input wire logic                         clock,
  input wire logic                         rst,
  // inputs watched
  input wire logic                         supply_ok,
  input wire logic [`DPDL_PCT_W-1:0]       duty_limit_pct,
  input wire logic                         nvm_rd_valid,
  // outputs watched
  input wire logic                         nvm_rd_req,
  input wire logic [`DPDL_NVM_ADDR_W-1:0]  nvm_addr,
  input wire logic                         pulse_width_out,
  input wire logic                         low_side_gate_drive,
  input wire logic                         regulating
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic [`DPDL_PCT_W-1:0] pct_c;   // ceiling percent, capped at full
  logic [9:0]             lim;     // ceiling in clock cycles
  logic [15:0]            hi_run;  // high samples in the current run
  assign pct_c = (duty_limit_pct > `DPDL_PCT_FULL) ? `DPDL_PCT_FULL : duty_limit_pct;
  assign lim   = 10'((32'h1f4 * 32'(pct_c)) / 32'h64);
  // run length of the high-side pulse, saturating
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_run <= 16'h0000;
    end else if (!pulse_width_out) begin
      hi_run <= 16'h0000;
    end else if (hi_run != 16'hffff) begin
      hi_run <= hi_run + 16'h0001;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  a_hold_outputs_low: assert property (!supply_ok [*2] |=>
    !pulse_width_out && !low_side_gate_drive && !regulating) else $error("outputs not low");
  a_hold_no_read: assert property (!supply_ok [*2] |=> !nvm_rd_req)
    else $error("read during supply hold");
  a_read_pulse: assert property (nvm_rd_req |=> !nvm_rd_req)
    else $error("read request too long");
  a_read_addr_range: assert property (nvm_rd_req |-> nvm_addr != 2'h3)
    else $error("read address out of range");
  a_read_order: assert property (nvm_rd_req && nvm_addr != 2'h0 |->
    $past(nvm_addr) == nvm_addr - 2'h1) else $error("read order broken");
  a_run_after_load: assert property (nvm_rd_valid && nvm_addr == 2'h2 && !regulating
    |-> ##[1:2] regulating) else $error("regulation late");
  a_run_needs_load: assert property ($rose(regulating) |-> nvm_addr == 2'h2)
    else $error("regulation before load");
  a_pulse_needs_run: assert property (pulse_width_out |-> regulating)
    else $error("pulse while not regulating");
  a_low_side_comp: assert property (regulating [*3] |->
    low_side_gate_drive != pulse_width_out) else $error("low side overlaps pulse");
  a_duty_ceiling: assert property (pulse_width_out && lim < 10'h1f4 &&
    $past(duty_limit_pct, 2) == duty_limit_pct |-> hi_run < 16'(lim))
    else $error("pulse beyond ceiling");
  a_limit_holds_low: assert property ($fell(pulse_width_out) && hi_run == 16'(lim) &&
    lim != 10'h000 && lim < 10'h1ec |-> !pulse_width_out [*8]) else $error("pulse restarted");
  // main scenarios
  c_load_done: cover property ($rose(regulating));
  c_pulse: cover property ($rose(pulse_width_out));
  c_limit_hit: cover property ($fell(pulse_width_out) && hi_run == 16'(lim));
endmodule

bind dpdl_top dpdl_props u_props (
  .clock(clock), .rst(rst), .supply_ok(supply_ok), .duty_limit_pct(duty_limit_pct),
  .nvm_rd_valid(nvm_rd_valid), .nvm_rd_req(nvm_rd_req), .nvm_addr(nvm_addr),
  .pulse_width_out(pulse_width_out), .low_side_gate_drive(low_side_gate_drive),
  .regulating(regulating)
);

`default_nettype wire

// >>> dpdl_stage_model.sv
// far-side model: coefficient store and power stage error source
`include "dpdl_params.svh"
`default_nettype none

module dpdl_stage_model
(
  // clock
  input  wire logic                        clock,
  // coefficient read port
  input  wire logic                        nvm_rd_req,
  input  wire logic [`DPDL_NVM_ADDR_W-1:0] nvm_addr,
  output var  logic                        nvm_rd_valid,
  output var  logic [`DPDL_COEF_W-1:0]     nvm_rd_data,
  // error samples
  output var  logic                        err_valid,
  output var  logic [`DPDL_ERR_W-1:0]      err_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`DPDL_COEF_W-1:0] coef_mem [3];  // set by the bench
  int unsigned             lag = 0;       // extra answer delay
  int unsigned             cnt = 0;       // cycles to the answer
  initial begin
    nvm_rd_valid = 1'b0;
    nvm_rd_data  = 8'h00;
    err_valid    = 1'b0;
    err_code     = 6'h00;
  end
  // answer each read lag+1 cycles after it is seen, off the falling edge
  always @(negedge clock) begin
    if (cnt == 1) begin
      nvm_rd_valid <= 1'b1;
      nvm_rd_data  <= coef_mem[nvm_addr];
    end else begin
      nvm_rd_valid <= 1'b0;
      nvm_rd_data  <= ~nvm_rd_data;  // no stale byte between answers
    end
    if (nvm_rd_req) begin
      cnt <= lag + 1;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  // one quantised error sample per call, back to back if called again
  task automatic send(input logic [`DPDL_ERR_W-1:0] code);
    @(negedge clock);
    err_valid = 1'b1;
    err_code  = code;
  endtask
  // release the sample lines, code inverted so nothing stale shows
  task automatic idle();
    @(negedge clock);
    err_valid = 1'b0;
    err_code  = ~err_code;
  endtask
endmodule

`default_nettype wire

// >>> digital_pid_duty_limit_tb.sv
// self-checking bench for the duty-limited pid core
`include "dpdl_params.svh"
`default_nettype none

module digital_pid_duty_limit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        clock, rst, supply_ok, err_valid, nvm_rd_req, nvm_rd_valid;
  logic                        pulse_width_out, low_side_gate_drive, regulating;
  logic [`DPDL_ERR_W-1:0]      err_code;
  logic [`DPDL_PCT_W-1:0]      duty_limit_pct;
  logic [`DPDL_NVM_ADDR_W-1:0] nvm_addr;
  logic [`DPDL_COEF_W-1:0]     nvm_rd_data;
  logic [15:0]                 exp_q [$];  // expected high cycles per period
  logic [15:0]                 hi_cnt;     // high samples in the window
  logic [15:0]                 lo_cnt;     // low-side samples in the window
  logic [15:0]                 exp_v;      // oldest expected high count
  int fails = 0, n_compared = 0, cycles = 0, win = 0, integ, prev_e, kc [3];

  dpdl_top dut (.clock(clock), .rst(rst), .supply_ok(supply_ok), .err_valid(err_valid),
    .err_code(err_code), .duty_limit_pct(duty_limit_pct), .nvm_rd_req(nvm_rd_req),
    .nvm_addr(nvm_addr), .nvm_rd_valid(nvm_rd_valid), .nvm_rd_data(nvm_rd_data),
    .pulse_width_out(pulse_width_out), .low_side_gate_drive(low_side_gate_drive),
    .regulating(regulating));
  dpdl_stage_model stage (.clock(clock), .nvm_rd_req(nvm_rd_req), .nvm_addr(nvm_addr),
    .nvm_rd_valid(nvm_rd_valid), .nvm_rd_data(nvm_rd_data), .err_valid(err_valid),
    .err_code(err_code));

  // ---------------------------------------------------------------
  // clock, timeout, reporting
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // reference compensator and pulse measurement
  // ---------------------------------------------------------------
  function automatic int model(input logic [`DPDL_ERR_W-1:0] code);
    int e, s;
    e = int'($signed(code));
    integ = integ + e;
    if (integ > 32'sh7fff) integ = 32'sh7fff;
    if (integ < -32'sh8000) integ = -32'sh8000;
    s = (e * kc[0] + integ * kc[1] + (e - prev_e) * kc[2]) >>> 4;
    prev_e = e;
    return (s < 0) ? 0 : ((s > 32'sh1f4) ? 32'sh1f4 : s);
  endfunction
  // note the expected count, then open a one-period window
  task automatic measure(input int w);
    int c;
    c = (32'sh1f4 * ((duty_limit_pct > 7'h64) ? 32'sh64 : int'(duty_limit_pct))) / 32'sh64;
    exp_q.push_back(16'((w < c) ? w : c));
    @(negedge clock);
    hi_cnt = 16'h0000;
    lo_cnt = 16'h0000;
    win = 500;
    while (win != 0) @(negedge clock);
  endtask
  // count high samples and compare with the oldest note
  always @(posedge clock) begin
    if (win > 0) begin
      hi_cnt = hi_cnt + 16'(pulse_width_out);
      lo_cnt = lo_cnt + 16'(low_side_gate_drive);
      win = win - 1;
      if (win == 0) begin
        exp_v = exp_q.pop_front();
        check(hi_cnt, exp_v, "high cycles");
        check(lo_cnt, 16'h01f4 - exp_v, "low side cycles");
      end
    end
  end
  // new coefficients, raise the supply, wait for the load
  task automatic power_up();
    int n;
    for (int k = 0; k < 3; k++) begin
      kc[k] = $urandom_range(63);
      stage.coef_mem[k] = 8'(kc[k]);
    end
    stage.lag = $urandom_range(3);
    integ = 0;
    prev_e = 0;
    @(negedge clock);
    supply_ok = 1'b1;
    stage.send(6'h1f);  // dropped, load not finished
    stage.idle();
    n = 0;
    while (regulating !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check(16'(regulating), 16'h0001, "load done");
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [6:0] pcts [7] = '{7'h00, 7'h01, 7'h25, 7'h32, 7'h63, 7'h64, 7'h7f};
    logic [`DPDL_ERR_W-1:0] e;
    int w;
    void'($urandom(32'h20d76df5));
    rst = 1'b1;
    supply_ok = 1'b0;
    duty_limit_pct = 7'h32;
    repeat (8) @(negedge clock);
    check({13'h0, pulse_width_out, low_side_gate_drive, regulating}, 16'h0, "in reset");
    rst = 1'b0;
    repeat (20) @(negedge clock);
    check({13'h0, pulse_width_out, nvm_rd_req, regulating}, 16'h0, "supply hold");
    power_up();
    // seven ceilings from 0 to 127 percent, random errors, some back to back
    for (int i = 0; i < 14; i++) begin
      duty_limit_pct = pcts[i % 7];
      e = 6'($urandom);
      w = model(e);
      stage.send(e);
      if (i % 3 == 0) begin
        e = 6'($urandom);
        w = model(e);
        stage.send(e);
      end
      stage.idle();
      repeat (1000) @(negedge clock);
      measure(w);
    end
    // supply lost mid-run, then reload and regulate again
    supply_ok = 1'b0;
    repeat (3) @(negedge clock);
    check({13'h0, pulse_width_out, low_side_gate_drive, regulating}, 16'h0, "drop");
    duty_limit_pct = 7'h4b;
    power_up();
    w = model(6'h1f);
    stage.send(6'h1f);
    stage.idle();
    repeat (1000) @(negedge clock);
    measure(w);
    // external reset while running
    rst = 1'b1;
    @(negedge clock);
    check({13'h0, pulse_width_out, low_side_gate_drive, regulating}, 16'h0, "rst");
    finish_test();
  end
endmodule

`default_nettype wire
